// ### hdl/cgt_csr_top.sv
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
// Summary of operation
// - Gain register reads 1 at bit 0: gain control present.
// - Gain bit 1 reads 0, read-only: no absolute_setting_register control.
// - Gain bit 5 reads 0, read-only: single-shot adjustment absent.
// - Gain bit 6 always reads 1, read-only: gain cannot be switched off.
// - Gain bit 7 reads 0, read-only: manual gain only.
// - Gain value in bits 20-31, range 350 to 1023, default 370.
// - With 16-bit pixel output the gain value is limited to 350 to 511.
// - Setting 350 gives unity amplification, 0 dB.
// - Setting 1023 gives the maximum amplification, 25.9 dB.
// - Trigger register reads 1 at bit 0: trigger setup present.
// - Trigger bit 1 reads 0, read-only.
// - Trigger bit 6 is writable and enables triggered operation.
// - Trigger enable is 0 after reset.
// - Trigger bit 7 sets input polarity, used only for hardware sources.
// - Polarity 0 is low active, 1 high active; reset value 1.
// - Source bits 8-10: ports 0 to 3, code 7 software; default 0.
// - Mode bits 12-15: 0 programmable, 1 level; software source allows 0 only.
module cgt_csr_top
    import cgt_pkg::*;
(
    input  wire logic              clock,          // System clock, 200 MHz.
    input  wire logic              srst,           // Synchronous reset, active high.
    input  wire logic              hsel,           // Slave select.
    input  wire logic [31:0]       haddr,          // Byte address.
    input  wire logic [1:0]        htrans,         // Transfer type.
    input  wire logic              hwrite,         // Write when high.
    input  wire logic [2:0]        hsize,          // Transfer size, word only.
    input  wire logic [31:0]       hwdata,         // Write data.
    input  wire logic              hready,         // Bus ready.
    output logic      [31:0]       hrdata,         // Read data.
    output logic                   hreadyout,      // Slave ready.
    output logic                   hresp,          // Response, always OKAY.
    input  wire logic              pix_16bit,      // 16-bit pixel output selected.
    input  wire logic [PORT_N-1:0] trig_in,        // Trigger input pins, asynchronous.
    input  wire logic              sw_trig,        // Software trigger level.
    output logic      [GAIN_W-1:0] gain_value,     // Gain setting in force.
    output logic      [DB_W-1:0]   gain_db,        // Amplification, tenths of a dB.
    output logic                   trig_enable,    // Triggered operation on.
    output logic                   trig_polarity,  // 1 high active, 0 low active.
    output logic      [SRC_W-1:0]  trig_source,    // Selected trigger source.
    output logic      [MODE_W-1:0] trig_mode,      // Selected exposure mode.
    output logic                   trig_active     // Qualified trigger level.
);

    // =========================================================================
    // State
    // =========================================================================
    typedef struct packed {
        logic [GAIN_W-1:0] gain;
        logic              trig_en;
        logic              trig_pol;
        logic [SRC_W-1:0]  trig_src;
        logic [MODE_W-1:0] trig_mode;
        logic              wr_gain;
        logic              wr_trig;
        logic [31:0]       rdata;
        logic [PORT_N-1:0] sync_a;
        logic [PORT_N-1:0] sync_b;
        logic              trig_act;
    } cgt_state_t;

    cgt_state_t        st_q;
    cgt_state_t        st_d;
    logic              ap_ok;
    logic              rd_gain;
    logic              rd_trig;
    logic [SRC_W-1:0]  new_src;
    logic [MODE_W-1:0] new_mode;

    // =========================================================================
    // Helpers
    // =========================================================================
    function automatic logic [GAIN_W-1:0] clamp_gain(input logic [GAIN_W-1:0] v,
                                                    input logic              p16);
        if (v < GAIN_MIN) begin
            return GAIN_MIN;
        end else if (p16 && (v > GAIN_MAX_16)) begin
            return GAIN_MAX_16;
        end else if (v > GAIN_MAX_8) begin
            return GAIN_MAX_8;
        end
        return v;
    endfunction

    function automatic logic trig_ok(input logic [SRC_W-1:0]  s,
                                     input logic [MODE_W-1:0] m);
        logic src_ok;
        logic mode_ok;
        src_ok  = (s <= SRC_PORT_MAX) || (s == SRC_SOFT);
        mode_ok = (m == MODE_PROG) || ((m == MODE_LEVEL) && (s != SRC_SOFT));
        return src_ok && mode_ok;
    endfunction

    function automatic logic [31:0] read_word(input logic [31:0] a,
                                              input cgt_state_t  s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == GAIN_CTRL_OFS) begin
            w[PRESENT_BIT]                 = FLAG_PRESENT_VAL;
            w[ABS_CTRL_BIT]                = FLAG_ABS_VAL;
            w[ONE_PUSH_BIT]                = FLAG_ONE_PUSH_VAL;
            w[ON_OFF_BIT]                  = GAIN_ON_VAL;
            w[AUTO_MAN_BIT]                = FLAG_AUTO_VAL;
            w[GAIN_VAL_LSB +: GAIN_W]      = s.gain;
        end else if (a == TRIG_SETUP_OFS) begin
            w[PRESENT_BIT]                 = FLAG_PRESENT_VAL;
            w[ABS_CTRL_BIT]                = FLAG_ABS_VAL;
            w[ON_OFF_BIT]                  = s.trig_en;
            w[TRIG_POL_BIT]                = s.trig_pol;
            w[TRIG_SRC_LSB +: SRC_W]       = s.trig_src;
            w[TRIG_MODE_LSB +: MODE_W]     = s.trig_mode;
        end
        return w;
    endfunction

    // =========================================================================
    // Bus decode
    // =========================================================================
    // Every transfer completes with no wait state, so the slave never stalls.
    assign ap_ok     = hsel & htrans[1] & hready;
    assign rd_gain   = ap_ok & ~hwrite & (haddr == GAIN_CTRL_OFS);
    assign rd_trig   = ap_ok & ~hwrite & (haddr == TRIG_SETUP_OFS);
    assign new_src   = hwdata[TRIG_SRC_LSB +: SRC_W];
    assign new_mode  = hwdata[TRIG_MODE_LSB +: MODE_W];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // =========================================================================
    // Next state
    // =========================================================================
    always_comb begin
        st_d = st_q;
        // A format switch to 16-bit pulls a stored setting down at once.
        if (st_q.wr_gain) begin
            st_d.gain = clamp_gain(hwdata[GAIN_VAL_LSB +: GAIN_W], pix_16bit);
        end else begin
            st_d.gain = clamp_gain(st_q.gain, pix_16bit);
        end
        if (st_q.wr_trig) begin
            st_d.trig_en  = hwdata[ON_OFF_BIT];
            st_d.trig_pol = hwdata[TRIG_POL_BIT];
            // Source and mode change together or not at all.
            if (trig_ok(new_src, new_mode)) begin
                st_d.trig_src  = new_src;
                st_d.trig_mode = new_mode;
            end
        end
        st_d.wr_gain = ap_ok & hwrite & (haddr == GAIN_CTRL_OFS);
        st_d.wr_trig = ap_ok & hwrite & (haddr == TRIG_SETUP_OFS);
        // Reading from the next state returns a write made in the same cycle.
        if (ap_ok & ~hwrite) begin
            st_d.rdata = read_word(haddr, st_d);
        end else begin
            st_d.rdata = 32'h0000_0000;
        end
        st_d.sync_a = trig_in;
        st_d.sync_b = st_q.sync_a;
        if (st_q.trig_src == SRC_SOFT) begin
            st_d.trig_act = st_q.trig_en & sw_trig;
        end else begin
            st_d.trig_act = st_q.trig_en &
                            (st_q.sync_b[st_q.trig_src[1:0]] == st_q.trig_pol);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q.gain      <= GAIN_RST;
            st_q.trig_en   <= TRIG_EN_RST;
            st_q.trig_pol  <= TRIG_POL_RST;
            st_q.trig_src  <= TRIG_SRC_RST;
            st_q.trig_mode <= TRIG_MODE_RST;
            st_q.wr_gain   <= 1'b0;
            st_q.wr_trig   <= 1'b0;
            st_q.rdata     <= 32'h0000_0000;
            st_q.sync_a    <= 4'h0;
            st_q.sync_b    <= 4'h0;
            st_q.trig_act  <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // =========================================================================
    // Gain scale
    // =========================================================================
    cgt_gain_db u_gain_db (
        .clock      (clock),
        .srst       (srst),
        .gain_value (st_q.gain),
        .gain_db    (gain_db)
    );

    assign hrdata        = st_q.rdata;
    assign gain_value    = st_q.gain;
    assign trig_enable   = st_q.trig_en;
    assign trig_polarity = st_q.trig_pol;
    assign trig_source   = st_q.trig_src;
    assign trig_mode     = st_q.trig_mode;
    assign trig_active   = st_q.trig_act;

    // =========================================================================
    // Assertions
    // =========================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_gain_present;
        rd_gain |=> hrdata[PRESENT_BIT];
    endproperty
    a_gain_present: assert property (p_gain_present) else $error("gain present flag low");

    property p_gain_abs;
        rd_gain |=> !hrdata[ABS_CTRL_BIT];
    endproperty
    a_gain_abs: assert property (p_gain_abs) else $error("gain absolute flag set");

    property p_gain_one_push;
        rd_gain |=> !hrdata[ONE_PUSH_BIT];
    endproperty
    a_gain_one_push: assert property (p_gain_one_push) else $error("one push flag set");

    property p_gain_on;
        rd_gain |=> hrdata[ON_OFF_BIT];
    endproperty
    a_gain_on: assert property (p_gain_on) else $error("gain switch reads off");

    property p_gain_manual;
        rd_gain |=> !hrdata[AUTO_MAN_BIT] && (hrdata[GAIN_VAL_LSB +: GAIN_W] == gain_value);
    endproperty
    a_gain_manual: assert property (p_gain_manual) else $error("gain mode or value wrong");

    property p_gain_range;
        $fell(srst) |-> (gain_value == GAIN_RST) ##1
            (gain_value >= GAIN_MIN && gain_value <= GAIN_MAX_8) [*3];
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain default or range bad");

    property p_gain_16;
        pix_16bit |=> gain_value <= GAIN_MAX_16;
    endproperty
    a_gain_16: assert property (p_gain_16) else $error("16-bit gain above limit");

    property p_unity;
        gain_value == GAIN_MIN |=> gain_db == DB_UNITY;
    endproperty
    a_unity: assert property (p_unity) else $error("unity setting not 0 dB");

    property p_max_db;
        gain_value == GAIN_MAX_8 |=> gain_db == DB_MAX;
    endproperty
    a_max_db: assert property (p_max_db) else $error("max setting not 25.9 dB");

    property p_trig_present;
        rd_trig |=> hrdata[PRESENT_BIT] && !hrdata[ABS_CTRL_BIT];
    endproperty
    a_trig_present: assert property (p_trig_present) else $error("trigger flags wrong");

    property p_trig_reserved;
        rd_trig |=> (hrdata[15:0] == 16'h0000) && (hrdata[ONE_PUSH_BIT +: 4] == 4'h0);
    endproperty
    a_trig_reserved: assert property (p_trig_reserved) else $error("reserved bits nonzero");

    property p_trig_write;
        st_q.wr_trig |=> trig_enable == $past(hwdata[ON_OFF_BIT]);
    endproperty
    a_trig_write: assert property (p_trig_write) else $error("enable write lost");

    property p_trig_reset;
        $fell(srst) |-> !trig_enable && trig_polarity && trig_source == TRIG_SRC_RST;
    endproperty
    a_trig_reset: assert property (p_trig_reset) else $error("trigger reset values bad");

    property p_trig_pol;
        trig_enable && trig_source <= SRC_PORT_MAX
            && st_q.sync_b[trig_source[1:0]] != trig_polarity |=> !trig_active;
    endproperty
    a_trig_pol: assert property (p_trig_pol) else $error("inactive level fired");

    property p_src_legal;
        trig_source <= SRC_PORT_MAX || trig_source == SRC_SOFT;
    endproperty
    a_src_legal: assert property (p_src_legal) else $error("illegal trigger source");

    property p_soft_mode;
        trig_source == SRC_SOFT |-> trig_mode == MODE_PROG;
    endproperty
    a_soft_mode: assert property (p_soft_mode) else $error("software source not mode 0");

    c_trig_fire: cover property (trig_enable ##1 trig_active);
    c_gain_clamp: cover property (pix_16bit && gain_value == GAIN_MAX_16);
    c_soft_src: cover property (trig_source == SRC_SOFT && trig_active);

endmodule

// ### hdl/cgt_gain_db.sv
`timescale 1ns/100ps
module cgt_gain_db
    import cgt_pkg::*;
(
    input  wire logic              clock,      // System clock.
    input  wire logic              srst,       // Synchronous reset, active high.
    input  wire logic [GAIN_W-1:0] gain_value, // Clamped gain setting.
    output logic      [DB_W-1:0]   gain_db     // Amplification in tenths of a dB.
);

    // =========================================================================
    // State
    // =========================================================================
    typedef struct packed {
        logic [DB_W-1:0] db;
    } cgt_db_state_t;

    cgt_db_state_t st_q;
    cgt_db_state_t st_d;
    logic [17:0]   prod;

    // The setting scales linearly in dB between the two end points. The
    // constant divide is costly but keeps the end points exact.
    always_comb begin
        st_d = st_q;
        prod = 18'(gain_value - GAIN_MIN) * 18'(DB_MAX) + GAIN_ROUND;
        st_d.db = DB_W'(prod / GAIN_SPAN);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q.db <= DB_UNITY;
        end else begin
            st_q <= st_d;
        end
    end

    assign gain_db = st_q.db;

endmodule

// ### hdl/cgt_pkg.sv
package cgt_pkg;

    // =========================================================================
    // Bit numbering: field bit 0 is the most significant bit of the word.
    // =========================================================================
    function automatic int doc_bit(input int n);
        return 31 - n;
    endfunction

    // =========================================================================
    // Register map
    // =========================================================================
    localparam logic [31:0] GAIN_CTRL_OFS  = 32'h0000_0820;
    localparam logic [31:0] TRIG_SETUP_OFS = 32'h0000_0830;

    // =========================================================================
    // Field positions
    // =========================================================================
    localparam int PRESENT_BIT   = doc_bit(0);
    localparam int ABS_CTRL_BIT  = doc_bit(1);
    localparam int ONE_PUSH_BIT  = doc_bit(5);
    localparam int ON_OFF_BIT    = doc_bit(6);
    localparam int AUTO_MAN_BIT  = doc_bit(7);
    localparam int TRIG_POL_BIT  = doc_bit(7);
    localparam int TRIG_SRC_LSB  = doc_bit(10);
    localparam int TRIG_MODE_LSB = doc_bit(15);
    localparam int GAIN_VAL_LSB  = doc_bit(31);

    localparam int GAIN_W = 12;
    localparam int SRC_W  = 3;
    localparam int MODE_W = 4;
    localparam int DB_W   = 9;
    localparam int PORT_N = 4;

    // =========================================================================
    // Fixed flag values and reset values
    // =========================================================================
    localparam logic              FLAG_PRESENT_VAL  = 1'b1;
    localparam logic              FLAG_ABS_VAL      = 1'b0;
    localparam logic              FLAG_ONE_PUSH_VAL = 1'b0;
    localparam logic              GAIN_ON_VAL       = 1'b1;
    localparam logic              FLAG_AUTO_VAL     = 1'b0;
    localparam logic [GAIN_W-1:0] GAIN_RST          = 12'h172;
    localparam logic              TRIG_EN_RST       = 1'b0;
    localparam logic              TRIG_POL_RST      = 1'b1;
    localparam logic [SRC_W-1:0]  TRIG_SRC_RST      = 3'h0;
    localparam logic [MODE_W-1:0] TRIG_MODE_RST     = 4'h0;

    // =========================================================================
    // Gain limits and amplification scale (tenths of a dB)
    // =========================================================================
    localparam logic [GAIN_W-1:0] GAIN_MIN    = 12'h15E;
    localparam logic [GAIN_W-1:0] GAIN_MAX_8  = 12'h3FF;
    localparam logic [GAIN_W-1:0] GAIN_MAX_16 = 12'h1FF;
    localparam logic [17:0]       GAIN_SPAN   = 18'h002A1;
    localparam logic [17:0]       GAIN_ROUND  = 18'h00150;
    localparam logic [DB_W-1:0]   DB_MAX      = 9'h103;
    localparam logic [DB_W-1:0]   DB_UNITY    = 9'h000;

    // =========================================================================
    // Trigger encodings
    // =========================================================================
    localparam logic [SRC_W-1:0]  SRC_PORT_MAX = 3'h3;
    localparam logic [SRC_W-1:0]  SRC_SOFT     = 3'h7;
    localparam logic [MODE_W-1:0] MODE_PROG    = 4'h0;
    localparam logic [MODE_W-1:0] MODE_LEVEL   = 4'h1;

endpackage

// ### verif/camera_gain_trigger_csrs_tb.sv
`timescale 1ns/100ps
module camera_gain_trigger_csrs_tb;
    import cgt_pkg::*;

    // =========================================================================
    // Signals
    // =========================================================================
    logic              clock;
    logic              srst;
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic              hready;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic              pix_16bit;
    logic [PORT_N-1:0] trig_in;
    logic              sw_trig;
    logic [GAIN_W-1:0] gain_value;
    logic [DB_W-1:0]   gain_db;
    logic              trig_enable;
    logic              trig_polarity;
    logic [SRC_W-1:0]  trig_source;
    logic [MODE_W-1:0] trig_mode;
    logic              trig_active;
    logic [31:0]       lf;
    logic [31:0]       rd;
    int                err_total;
    int                tests_run;
    int                cycles;
    int                m_gain;
    int                m_pix;
    int                m_en;
    int                m_pol;
    int                m_src;
    int                m_mode;

    assign hready = hreadyout;

    cgt_csr_top dut (
        .clock         (clock),
        .srst          (srst),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hready),
        .hrdata        (hrdata),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .pix_16bit     (pix_16bit),
        .trig_in       (trig_in),
        .sw_trig       (sw_trig),
        .gain_value    (gain_value),
        .gain_db       (gain_db),
        .trig_enable   (trig_enable),
        .trig_polarity (trig_polarity),
        .trig_source   (trig_source),
        .trig_mode     (trig_mode),
        .trig_active   (trig_active)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // =========================================================================
    // Model, compares and bus cycles
    // =========================================================================
    function automatic logic [31:0] next_lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] exp_pins();
        int   db;
        logic act;
        db = ((m_gain - 350) * 259 + 336) / 673;
        act = (m_en == 1) && ((m_src == 7) ? sw_trig : (trig_in[m_src] == m_pol[0]));
        return {1'b0, m_gain[11:0], db[8:0], m_en[0], m_pol[0], m_src[2:0], m_mode[3:0], act};
    endfunction

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t ns: register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t ns: outputs %h expected %h", $time, got, exp);
        end
    endtask

    // Entered right after a rising edge; the data phase runs with htrans idle and a following call
    // starts its address phase only after it, so transfers are never back-to-back.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] data);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= 3'h2;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        data = hrdata;
    endtask

    // Four edges cover the pin synchroniser and the one-cycle lag of the dB output.
    task automatic settle();
        repeat (4) @(posedge clock);
        @(negedge clock);
        cmp_pin({1'b0, gain_value, gain_db, trig_enable, trig_polarity, trig_source,
                 trig_mode, trig_active}, exp_pins());
        @(posedge clock);
    endtask

    task automatic wr_gain(input int v);
        int lim;
        lim = (m_pix == 1) ? 511 : 1023;
        m_gain = (v < 350) ? 350 : ((v > lim) ? lim : v);
        bus(1'b1, GAIN_CTRL_OFS, 32'h7DFF_F000 | {20'h0, v[11:0]}, rd);
        bus(1'b0, GAIN_CTRL_OFS, 32'h0, rd);
        cmp_reg(rd, 32'h8200_0000 | 32'(m_gain));
        settle();
    endtask

    task automatic wr_trig(input int en, input int pol, input int src, input int mode);
        bus(1'b1, TRIG_SETUP_OFS,
            32'h7C10_FFFF | {6'h0, en[0], pol[0], src[2:0], 1'b0, mode[3:0], 16'h0}, rd);
        m_en = en;
        m_pol = pol;
        if ((src <= 3 || src == 7) && mode <= 1 && !(src == 7 && mode == 1)) begin
            m_src = src;
            m_mode = mode;
        end
        bus(1'b0, TRIG_SETUP_OFS, 32'h0, rd);
        cmp_reg(rd, 32'h8000_0000 | 32'(m_en << 25) | 32'(m_pol << 24)
                | 32'(m_src << 21) | 32'(m_mode << 16));
        lf = next_lf(lf);
        trig_in <= lf[3:0];
        sw_trig <= lf[4];
        settle();
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A whole run needs about 450 cycles; the ceiling leaves wide margin.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    // =========================================================================
    // Test sequence
    // =========================================================================
    initial begin
        int gv1[$];
        int gv2[$];
        gv1 = {349, 350, 1023, 1024, 4095, 0, 370};
        gv2 = {600, 511, 512, 400, 350};
        {srst, hsel, hwrite, pix_16bit, sw_trig} = 5'b10000;
        {haddr, hwdata, htrans, hsize, trig_in} = '0;
        lf = 32'hF2DE_33E4;
        {err_total, tests_run, cycles} = '0;
        m_gain = 370;
        m_pix = 0;
        m_en = 0;
        m_pol = 1;
        m_src = 0;
        m_mode = 0;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        settle();
        bus(1'b0, GAIN_CTRL_OFS, 32'h0, rd);
        cmp_reg(rd, 32'h8200_0172);
        bus(1'b0, TRIG_SETUP_OFS, 32'h0, rd);
        cmp_reg(rd, 32'h8100_0000);
        $display("test reset values done");
        foreach (gv1[i]) wr_gain(gv1[i]);
        for (int i = 0; i < 4; i++) begin
            lf = next_lf(lf);
            wr_gain(int'(lf[11:0]));
        end
        wr_gain(1023);
        pix_16bit <= 1'b1;
        m_pix = 1;
        m_gain = 511;
        settle();
        pix_16bit <= 1'b0;
        m_pix = 0;
        settle();
        pix_16bit <= 1'b1;
        m_pix = 1;
        foreach (gv2[i]) wr_gain(gv2[i]);
        pix_16bit <= 1'b0;
        m_pix = 0;
        $display("test gain range done");
        for (int s = 0; s < 8; s++) begin
            for (int m = 0; m < 3; m++) begin
                lf = next_lf(lf);
                wr_trig(int'(lf[0] | lf[2]), int'(lf[1]), s, m);
            end
        end
        $display("test trigger setup done");
        // Load non-default values first so that a second reset has work to undo.
        wr_trig(1, 0, 2, 1);
        wr_gain(900);
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        m_gain = 370;
        m_en = 0;
        m_pol = 1;
        m_src = 0;
        m_mode = 0;
        @(posedge clock);
        settle();
        bus(1'b0, TRIG_SETUP_OFS, 32'h0, rd);
        cmp_reg(rd, 32'h8100_0000);
        bus(1'b0, GAIN_CTRL_OFS, 32'h0, rd);
        cmp_reg(rd, 32'h8200_0172);
        $display("test mid-run reset done");
        bus(1'b0, 32'h0000_0824, 32'h0, rd);
        cmp_reg(rd, 32'h0);
        bus(1'b1, 32'h0000_0824, 32'hFFFF_FFFF, rd);
        bus(1'b1, 32'h0000_0834, 32'hFFFF_FFFF, rd);
        settle();
        cmp_pin({30'h0, hreadyout, hresp}, 32'h2);
        $display("test unmapped access done");
        final_report();
    end
endmodule
